// File: verilog/copper_phy_status_error_counters.sv
// Status word, clear-on-read error tallies and window selector of the copper PHY
// Functional notes
// - Bit 0 latches MLT3 error, clears on read
// - Bit 15 latches selector mismatch until read
// - Bit 14 shows speed downgrade live
// - Bit 13 shows crossed pair assignment live
// - Bit 11 latches remote not-OK low until read
// - Bit 10 latches local not-OK low until read
// - Bit 9 shows descrambler lock unlatched
// - Bit 8 shows link up
// - Bit 7 latches any CRC error since read
// - Bit 6 latches carrier extension error until read
// - Bits 5, 4 latch bad delimiters, clear on read
// - Bit 3 latches invalid code packet
// - Bit 2 latches transmit error code packet
// - Bit 1 latches descrambler lock loss
// - 16-bit rx error tally saturates, clears on read
// - Control bit swaps in serial-link CRC count
// - 8-bit false carrier tally saturates, clears read
// - Upper byte counts local not-OK entries
// - Lower byte counts remote not-OK entries
// - Control bit swaps in CRC error bits
// - Select code routes window data location
// - Host sets code and number, accesses, clears select
module copper_phy_status_error_counters
(
    input  wire logic                             clk_sys_i,          // Management clock
    input  wire logic                             rst_n_i,            // Async reset, low
    input  wire phy_status_pkg::mgmt_req_s        mgmt_req_i,         // Register access
    output logic [15:0]                           mgmt_rdata_o,       // Read data
    output logic                                  mgmt_rvalid_o,      // Read data valid
    input  wire phy_status_pkg::rx_events_s       rx_events_i,        // Event pulses
    input  wire phy_status_pkg::rx_levels_s       rx_levels_i,        // Live levels
    input  wire logic                             serdes_crc_mode_i,  // Show serial-link CRC
    input  wire logic [15:0]                      serdes_crc_count_i, // Serial-link CRC count
    input  wire logic [15:0]                      serdes_data_i,      // Serial-link data bits
    input  wire logic                             crc_bits_mode_i,    // Show CRC error bits
    input  wire logic [15:0]                      crc_err_bits_i,     // CRC error bits
    output phy_status_pkg::window_target_e        window_target_o,    // Routed window target
    output logic [7:0]                            window_reg_num_o,   // Expansion reg number
    output logic                                  window_rd_o,        // Window data read
    output logic                                  window_wr_o,        // Window data write
    output logic [15:0]                           window_wdata_o,     // Window write data
    input  wire logic [15:0]                      window_rdata_i      // Window read data
);
    import phy_status_pkg::*;

    // Decoded accesses
    logic        dev_hit;                 // Request addressed to this device
    logic        rd_status;               // Read of status word
    logic        rd_rx_err;               // Read of rx error tally
    logic        rd_false_car;            // Read of false carrier tally
    logic        rd_fault;                // Read of receiver fault tally
    logic        wr_rx_err;               // Write of rx error tally
    logic        wr_false_car;            // Write of false carrier tally
    logic        wr_fault;                // Write of receiver fault tally
    logic        win_access;              // Window data location addressed

    // Storage
    logic [NUM_STICKY-1:0] sticky_reg;    // Latch-high status flags
    logic [NUM_STICKY-1:0] sticky_evt;    // Events feeding those flags
    logic        remote_nok_reg;          // Remote not-OK seen since read
    logic        local_nok_reg;           // Local not-OK seen since read
    logic        remote_ok_d_reg;         // Previous remote OK level
    logic        local_ok_d_reg;          // Previous local OK level
    logic [15:0] rx_err_tally_reg;        // Receive error tally
    logic [7:0]  false_car_tally_reg;     // False carrier tally
    logic [7:0]  local_fault_tally_reg;   // Local not-OK entry tally
    logic [7:0]  remote_fault_tally_reg;  // Remote not-OK entry tally
    logic [15:0] window_sel_reg;          // Window selector
    logic [15:0] rdata_reg;               // Registered read data
    logic        rvalid_reg;              // Registered read valid

    // Derived
    logic        local_nok_entry;         // Local receiver entered not-OK
    logic        remote_nok_entry;        // Remote receiver entered not-OK
    logic [15:0] status_word;             // Assembled status word
    logic [15:0] rdata_next;              // Read mux result

    // Address decode
    assign dev_hit      = (mgmt_req_i.devad == DEVICE_ADDR);
    assign rd_status    = mgmt_req_i.rd && dev_hit && (mgmt_req_i.addr == EXT_STATUS_OFS);
    assign rd_rx_err    = mgmt_req_i.rd && dev_hit && (mgmt_req_i.addr == RX_ERR_TALLY_OFS);
    assign rd_false_car = mgmt_req_i.rd && dev_hit && (mgmt_req_i.addr == FALSE_CAR_OFS);
    assign rd_fault     = mgmt_req_i.rd && dev_hit && (mgmt_req_i.addr == RX_FAULT_OFS);
    assign wr_rx_err    = mgmt_req_i.wr && dev_hit && (mgmt_req_i.addr == RX_ERR_TALLY_OFS);
    assign wr_false_car = mgmt_req_i.wr && dev_hit && (mgmt_req_i.addr == FALSE_CAR_OFS);
    assign wr_fault     = mgmt_req_i.wr && dev_hit && (mgmt_req_i.addr == RX_FAULT_OFS);
    assign win_access   = dev_hit && (mgmt_req_i.addr == WINDOW_DATA_OFS);

    // Entry edges into the not-OK state
    assign local_nok_entry  = local_ok_d_reg && !rx_levels_i.local_rx_ok;
    assign remote_nok_entry = remote_ok_d_reg && !rx_levels_i.remote_rx_ok;

    // Event vector in flag order: mismatch, then bits 7 down to 0
    assign sticky_evt = {rx_events_i.selector_mismatch,
                         rx_events_i.crc_error,
                         rx_events_i.carrier_ext_error,
                         rx_events_i.bad_start_of_stream_delimiter,
                         rx_events_i.bad_end_of_stream_delimiter,
                         rx_events_i.invalid_code_packet,
                         rx_events_i.tx_error_code_packet,
                         rx_events_i.lock_lost,
                         rx_events_i.mlt3_code_error};

    // Latch-high flags, one per bit; set wins over read clear
    genvar gi;
    generate
        for (gi = 0; gi < NUM_STICKY; gi++)
        begin : g_sticky
            always_ff @(posedge clk_sys_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    sticky_reg[gi] <= 1'b0;
                else if (sticky_evt[gi])
                    sticky_reg[gi] <= 1'b1;
                else if (rd_status)
                    sticky_reg[gi] <= 1'b0;
            end
        end
    endgenerate

    // Previous OK levels for entry detection
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            local_ok_d_reg  <= 1'b0;
            remote_ok_d_reg <= 1'b0;
        end
        else
        begin
            local_ok_d_reg  <= rx_levels_i.local_rx_ok;
            remote_ok_d_reg <= rx_levels_i.remote_rx_ok;
        end
    end

    // Latch-low receiver status; held until read while OK again
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            local_nok_reg  <= 1'b0;
            remote_nok_reg <= 1'b0;
        end
        else
        begin
            // Not-OK level holds the flag; a read while OK releases it
            if (!rx_levels_i.local_rx_ok)
                local_nok_reg <= 1'b1;
            else if (rd_status)
                local_nok_reg <= 1'b0;
            if (!rx_levels_i.remote_rx_ok)
                remote_nok_reg <= 1'b1;
            else if (rd_status)
                remote_nok_reg <= 1'b0;
        end
    end

    // Receive error tally; read clear keeps a same-cycle event
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rx_err_tally_reg <= TALLY16_RESET;
        else if (rd_rx_err)
            rx_err_tally_reg <= {15'h0000, rx_events_i.rx_error_packet};
        else if (wr_rx_err)
            rx_err_tally_reg <= mgmt_req_i.wdata;
        else if (rx_events_i.rx_error_packet && rx_err_tally_reg != TALLY16_MAX)
            rx_err_tally_reg <= rx_err_tally_reg + 16'h0001;
    end

    // False carrier tally
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            false_car_tally_reg <= TALLY8_RESET;
        else if (rd_false_car)
            false_car_tally_reg <= {7'h00, rx_events_i.false_carrier};
        else if (wr_false_car)
            false_car_tally_reg <= mgmt_req_i.wdata[7:0];
        else if (rx_events_i.false_carrier && false_car_tally_reg != TALLY8_MAX)
            false_car_tally_reg <= false_car_tally_reg + 8'h01;
    end

    // Receiver fault tallies, local in upper byte, remote in lower
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            local_fault_tally_reg  <= TALLY8_RESET;
            remote_fault_tally_reg <= TALLY8_RESET;
        end
        else if (rd_fault)
        begin
            local_fault_tally_reg  <= {7'h00, local_nok_entry};
            remote_fault_tally_reg <= {7'h00, remote_nok_entry};
        end
        else if (wr_fault)
        begin
            local_fault_tally_reg  <= mgmt_req_i.wdata[15:8];
            remote_fault_tally_reg <= mgmt_req_i.wdata[7:0];
        end
        else
        begin
            if (local_nok_entry && local_fault_tally_reg != TALLY8_MAX)
                local_fault_tally_reg <= local_fault_tally_reg + 8'h01;
            if (remote_nok_entry && remote_fault_tally_reg != TALLY8_MAX)
                remote_fault_tally_reg <= remote_fault_tally_reg + 8'h01;
        end
    end

    // Window selector, fully writable
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            window_sel_reg <= WINDOW_SEL_RESET;
        else if (mgmt_req_i.wr && dev_hit && mgmt_req_i.addr == WINDOW_SEL_OFS)
            window_sel_reg <= mgmt_req_i.wdata;
    end

    // Window routing from the select code
    always_comb
    begin
        case (window_sel_reg[WIN_CODE_MSB:WIN_CODE_LSB])
            WIN_CODE_EXPANSION: window_target_o = WIN_EXPANSION;
            WIN_CODE_BASEX:     window_target_o = WIN_BASEX;
            WIN_CODE_NONE:      window_target_o = WIN_NONE;
            default:            window_target_o = WIN_RESERVED;
        endcase
    end

    // Window data strobes pass only to a selected target
    assign window_reg_num_o = window_sel_reg[7:0];
    assign window_rd_o      = mgmt_req_i.rd && win_access &&
                              (window_target_o inside {WIN_EXPANSION, WIN_BASEX});
    assign window_wr_o      = mgmt_req_i.wr && win_access &&
                              (window_target_o inside {WIN_EXPANSION, WIN_BASEX});
    assign window_wdata_o   = mgmt_req_i.wdata;

    // Status word assembly; bit 12 reads zero
    always_comb
    begin
        status_word                   = 16'h0000;
        status_word[7:0]              = sticky_reg[7:0];
        status_word[SEL_MISMATCH_BIT] = sticky_reg[MISMATCH_IDX];
        status_word[DOWNGRADE_BIT]    = rx_levels_i.speed_downgraded;
        status_word[CROSSED_BIT]      = rx_levels_i.crossed_pair_assignment;
        status_word[REMOTE_OK_BIT]    = !remote_nok_reg;
        status_word[LOCAL_OK_BIT]     = !local_nok_reg;
        status_word[LOCKED_BIT]       = rx_levels_i.descrambler_locked;
        status_word[LINK_BIT]         = rx_levels_i.link_up;
    end

    // Read data mux; unmapped addresses read zero
    always_comb
    begin
        rdata_next = 16'h0000;
        if (dev_hit)
        begin
            case (mgmt_req_i.addr)
                EXT_STATUS_OFS:   rdata_next = status_word;
                RX_ERR_TALLY_OFS: rdata_next = serdes_crc_mode_i ? serdes_crc_count_i
                                                                 : rx_err_tally_reg;
                FALSE_CAR_OFS:    rdata_next = serdes_crc_mode_i ? serdes_data_i
                                                                 : {8'h00, false_car_tally_reg};
                RX_FAULT_OFS:
                begin
                    if (serdes_crc_mode_i)
                        rdata_next = serdes_data_i;
                    else if (crc_bits_mode_i)
                        rdata_next = crc_err_bits_i;
                    else
                        rdata_next = {local_fault_tally_reg, remote_fault_tally_reg};
                end
                WINDOW_DATA_OFS:  rdata_next = (window_target_o inside {WIN_EXPANSION, WIN_BASEX})
                                               ? window_rdata_i : 16'h0000;
                WINDOW_SEL_OFS:   rdata_next = window_sel_reg;
                default:          rdata_next = 16'h0000;
            endcase
        end
    end

    // Registered read answer, one cycle after the strobe
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdata_reg  <= 16'h0000;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= mgmt_req_i.rd;
            if (mgmt_req_i.rd)
                rdata_reg <= rdata_next;
        end
    end

    assign mgmt_rdata_o  = rdata_reg;
    assign mgmt_rvalid_o = rvalid_reg;

    // Checks on the bank's own behaviour
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    mlt3_flag_read_a: assert property (
        sticky_reg[0] && rd_status && !rx_events_i.mlt3_code_error
        |=> mgmt_rdata_o[0] && !sticky_reg[0])
        else $error("MLT3 flag not reported then cleared");

    mismatch_hold_a: assert property (
        rx_events_i.selector_mismatch || (sticky_reg[MISMATCH_IDX] && !rd_status)
        |=> sticky_reg[MISMATCH_IDX])
        else $error("Selector mismatch flag not held");

    remote_low_a: assert property (
        !rx_levels_i.remote_rx_ok ##1 !rd_status |=> !status_word[REMOTE_OK_BIT])
        else $error("Remote status released before read");

    local_low_a: assert property (
        !rx_levels_i.local_rx_ok |=> !status_word[LOCAL_OK_BIT])
        else $error("Local status not latched low");

    lock_live_a: assert property (
        rd_status |=> mgmt_rdata_o[LOCKED_BIT] == $past(rx_levels_i.descrambler_locked))
        else $error("Lock bit not live");

    rx_tally_sat_a: assert property (
        rx_err_tally_reg == TALLY16_MAX && !rd_rx_err && !wr_rx_err
        |=> rx_err_tally_reg == TALLY16_MAX)
        else $error("Rx error tally wrapped");

    rx_tally_inc_a: assert property (
        rx_events_i.rx_error_packet && !rd_rx_err && !wr_rx_err && rx_err_tally_reg < 16'h0010
        |=> rx_err_tally_reg == $past(rx_err_tally_reg) + 16'h0001)
        else $error("Rx error tally missed an event");

    fc_clear_keep_a: assert property (
        rd_false_car |=> false_car_tally_reg == {7'h00, $past(rx_events_i.false_carrier)})
        else $error("False carrier event lost on clear");

    fault_entry_a: assert property (
        local_nok_entry && !rd_fault && !wr_fault && local_fault_tally_reg != TALLY8_MAX
        |=> local_fault_tally_reg == $past(local_fault_tally_reg) + 8'h01)
        else $error("Local fault entry not counted");

    crc_swap_a: assert property (
        rd_rx_err && serdes_crc_mode_i |=> mgmt_rdata_o == $past(serdes_crc_count_i))
        else $error("Serial-link CRC count not shown");

    downgrade_live_a: assert property (
        rd_status |=> mgmt_rdata_o[DOWNGRADE_BIT] == $past(rx_levels_i.speed_downgraded))
        else $error("Downgrade bit not live");

    fc_tally_sat_a: assert property (
        false_car_tally_reg == TALLY8_MAX && !rd_false_car && !wr_false_car
        |=> false_car_tally_reg == TALLY8_MAX)
        else $error("False carrier tally wrapped");

    remote_entry_a: assert property (
        remote_nok_entry && !rd_fault && !wr_fault && remote_fault_tally_reg != TALLY8_MAX
        |=> remote_fault_tally_reg == $past(remote_fault_tally_reg) + 8'h01)
        else $error("Remote fault entry not counted");

    crc_bits_a: assert property (
        rd_fault && crc_bits_mode_i && !serdes_crc_mode_i |=> mgmt_rdata_o == $past(crc_err_bits_i))
        else $error("CRC error bits not shown");

    window_route_a: assert property (
        window_sel_reg[WIN_CODE_MSB:WIN_CODE_LSB] == WIN_CODE_NONE |-> !window_rd_o && !window_wr_o)
        else $error("Window strobe with no target");

    status_clear_c: cover property (rd_status ##1 mgmt_rvalid_o && mgmt_rdata_o[7:0] != 8'h00);
    tally_sat_c:    cover property (false_car_tally_reg == TALLY8_MAX);
    event_on_read_c: cover property (rd_status && rx_events_i.crc_error);
    window_exp_c:   cover property (window_rd_o && window_target_o == WIN_EXPANSION);

endmodule : copper_phy_status_error_counters

// File: verilog/phy_status_pkg.sv
// Package with register map, field positions and carriers of the status bank
package phy_status_pkg;

    // Management device address that owns this bank
    localparam logic [4:0]  DEVICE_ADDR       = 5'h07;

    // Register offsets
    localparam logic [15:0] EXT_STATUS_OFS    = 16'hFFF1;
    localparam logic [15:0] RX_ERR_TALLY_OFS  = 16'hFFF2;
    localparam logic [15:0] FALSE_CAR_OFS     = 16'hFFF3;
    localparam logic [15:0] RX_FAULT_OFS      = 16'hFFF4;
    localparam logic [15:0] WINDOW_DATA_OFS   = 16'hFFF5;
    localparam logic [15:0] WINDOW_SEL_OFS    = 16'hFFF7;

    // Values after reset
    localparam logic [15:0] TALLY16_RESET     = 16'h0000;
    localparam logic [7:0]  TALLY8_RESET      = 8'h00;
    localparam logic [15:0] WINDOW_SEL_RESET  = 16'h0000;

    // Saturation limits
    localparam logic [15:0] TALLY16_MAX       = 16'hFFFF;
    localparam logic [7:0]  TALLY8_MAX        = 8'hFF;

    // Status word bit positions
    localparam int SEL_MISMATCH_BIT  = 15;
    localparam int DOWNGRADE_BIT     = 14;
    localparam int CROSSED_BIT       = 13;
    localparam int REMOTE_OK_BIT     = 11;
    localparam int LOCAL_OK_BIT      = 10;
    localparam int LOCKED_BIT        = 9;
    localparam int LINK_BIT          = 8;

    // Window select field positions
    localparam int WIN_CODE_LSB      = 8;
    localparam int WIN_CODE_MSB      = 11;

    // Window select codes
    localparam logic [3:0] WIN_CODE_EXPANSION = 4'hF;
    localparam logic [3:0] WIN_CODE_BASEX     = 4'hE;
    localparam logic [3:0] WIN_CODE_NONE      = 4'h0;

    // Number of latch-high flags in the status word (bits 7:0 and 15)
    localparam int NUM_STICKY        = 9;
    localparam int MISMATCH_IDX      = 8;

    // Target reached through the window data location
    typedef enum logic [1:0] {
        WIN_NONE,
        WIN_EXPANSION,
        WIN_BASEX,
        WIN_RESERVED
    } window_target_e;

    // One-cycle event pulses from the receive datapath
    typedef struct packed {
        logic selector_mismatch;        // Partner selector field mismatch
        logic crc_error;                // CRC error seen
        logic carrier_ext_error;        // Carrier extension error
        logic bad_start_of_stream_delimiter; // False carrier
        logic bad_end_of_stream_delimiter;   // Premature end
        logic invalid_code_packet;      // Packet with invalid code
        logic tx_error_code_packet;     // Packet with transmit error code
        logic lock_lost;                // Descrambler lost lock
        logic mlt3_code_error;          // MLT3 coding error
        logic rx_error_packet;          // Non-collision packet with rx error
        logic false_carrier;            // False carrier at receive input
    } rx_events_s;

    // Live status levels from the datapath
    typedef struct packed {
        logic speed_downgraded;         // Advertised speed lowered
        logic crossed_pair_assignment;  // Pairs swapped
        logic remote_rx_ok;             // Remote receiver OK
        logic local_rx_ok;              // Local receiver OK
        logic descrambler_locked;       // Descrambler locked
        logic link_up;                  // Link established
    } rx_levels_s;

    // Management access request
    typedef struct packed {
        logic        rd;                // Read strobe, one cycle
        logic        wr;                // Write strobe, one cycle
        logic [4:0]  devad;             // Device address
        logic [15:0] addr;              // Register address
        logic [15:0] wdata;             // Write data
    } mgmt_req_s;

endpackage : phy_status_pkg

// File: verification/expansion_space_model.sv
// Partner model of the register space reached through the window data location
module expansion_space_model
(
    input  wire logic        clk_sys_i, // Management clock
    input  wire logic        wr_i,      // Window write strobe
    input  wire logic        rd_i,      // Window read strobe
    input  wire logic [7:0]  num_i,     // Register number
    input  wire logic [15:0] wdata_i,   // Write data
    output logic      [15:0] rdata_o    // Read data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [256]; // Register contents
    // Store on each window write
    always_ff @(posedge clk_sys_i)
    begin
        if (wr_i)
        begin
            mem[num_i] <= wdata_i;
        end
    end
    // Valid only during a read, otherwise a flipped pattern
    assign rdata_o = rd_i ? mem[num_i] : ~mem[num_i];
endmodule : expansion_space_model

// File: verification/copper_phy_status_error_counters_tb.sv
// Testbench of the status word, error tallies and window selector
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
    $display("ERROR %0t got %h exp %h", $time, a, e); end end
module copper_phy_status_error_counters_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import phy_status_pkg::*;
    logic           clk_sys_i = 1'b0; // Management clock
    logic           rst_n_i = 1'b0;   // Reset, low
    mgmt_req_s      req = '0;         // Host request
    rx_events_s     ev = '0;          // Event pulses
    rx_levels_s     lv = '1;          // Live levels
    logic           smode = 1'b0;     // Serial-link view
    logic           cmode = 1'b0;     // CRC bits view
    logic [15:0]    rdata;            // Read data
    logic           rvalid;           // Read valid
    logic           wrd;              // Window read
    logic           wwr;              // Window write
    logic [7:0]     wnum;             // Window number
    logic [15:0]    wwd;              // Window write data
    logic [15:0]    wrdat;            // Window read data
    logic [15:0]    got;              // Last read word
    window_target_e tgt;              // Routed window target
    int             failures = 0;     // Mismatches
    int             samples_checked = 0; // Comparisons
    int             sb [9] = '{0, 1, 2, 3, 4, 5, 6, 7, 15}; // Flag bit per event
    always #4 clk_sys_i = ~clk_sys_i;
    copper_phy_status_error_counters copper_phy_status_error_counters_i (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .mgmt_req_i(req),
        .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rvalid), .rx_events_i(ev),
        .rx_levels_i(lv), .serdes_crc_mode_i(smode), .serdes_crc_count_i(16'h1234),
        .serdes_data_i(16'h5A5A), .crc_bits_mode_i(cmode), .crc_err_bits_i(16'hC3C3),
        .window_target_o(tgt), .window_reg_num_o(wnum), .window_rd_o(wrd),
        .window_wr_o(wwr), .window_wdata_o(wwd), .window_rdata_i(wrdat));
    expansion_space_model expansion_space_model_i (.clk_sys_i(clk_sys_i), .wr_i(wwr),
        .rd_i(wrd), .num_i(wnum), .wdata_i(wwd), .rdata_o(wrdat));
    // One access held for one edge, answer checked after it
    task automatic acc(input logic r, input logic [4:0] dv, input logic [15:0] a,
                       input logic [15:0] d);
        @(posedge clk_sys_i);
        req <= '{rd: r, wr: !r, devad: dv, addr: a, wdata: d};
        @(posedge clk_sys_i);
        req <= '0;
        #1 got = rdata;
        if (r) `CHK(rvalid, 1'b1)
        else `CHK(rvalid, 1'b0)
    endtask : acc
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        acc(1'b1, DEVICE_ADDR, a, 16'h0000);
        `CHK(got, e)
    endtask : rd
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        acc(1'b0, DEVICE_ADDR, a, d);
    endtask : wr
    // Pulse one event (or dip one level) n times
    task automatic pulse(input int i, input int n, input bit lvl);
        repeat (n)
        begin
            @(posedge clk_sys_i);
            if (lvl) lv[i] <= 1'b0; else ev[i] <= 1'b1;
            @(posedge clk_sys_i);
            if (lvl) lv[i] <= 1'b1; else ev[i] <= 1'b0;
        end
    endtask : pulse
    task automatic close_out;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // Watchdog cuts a hang short
    initial
    begin
        #100000 failures++;
        close_out();
    end
    // Test sequence
    initial
    begin
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd(RX_ERR_TALLY_OFS, 16'h0000);
        rd(RX_FAULT_OFS, 16'h0000);
        rd(EXT_STATUS_OFS, 16'h6F00);
        @(posedge clk_sys_i) lv <= 6'h0C;
        rd(EXT_STATUS_OFS, 16'h0C00);
        @(posedge clk_sys_i) lv <= '1;
        $display("test levels done");
        for (int i = 0; i < 9; i++)
        begin
            pulse(i + 2, 1, 0);
            rd(EXT_STATUS_OFS, 16'h6F00 | (16'h0001 << sb[i]));
            rd(EXT_STATUS_OFS, 16'h6F00);
        end
        fork rd(EXT_STATUS_OFS, 16'h6F00); pulse(9, 1, 0); join
        rd(EXT_STATUS_OFS, 16'h6F80);
        fork rd(RX_ERR_TALLY_OFS, 16'h0000); pulse(1, 1, 0); join
        rd(RX_ERR_TALLY_OFS, 16'h0001);
        $display("test flags done");
        pulse(1, 3, 0);
        rd(RX_ERR_TALLY_OFS, 16'h0003);
        rd(RX_ERR_TALLY_OFS, 16'h0000);
        wr(RX_ERR_TALLY_OFS, 16'hFFFE);
        pulse(1, 3, 0);
        rd(RX_ERR_TALLY_OFS, TALLY16_MAX);
        wr(FALSE_CAR_OFS, 16'h00FE);
        pulse(0, 3, 0);
        rd(FALSE_CAR_OFS, 16'h00FF);
        rd(FALSE_CAR_OFS, 16'h0000);
        pulse(2, 1, 1);
        pulse(3, 2, 1);
        rd(EXT_STATUS_OFS, 16'h6300);
        rd(EXT_STATUS_OFS, 16'h6F00);
        rd(RX_FAULT_OFS, 16'h0102);
        $display("test tallies done");
        @(posedge clk_sys_i) smode <= 1'b1;
        rd(RX_ERR_TALLY_OFS, 16'h1234);
        rd(FALSE_CAR_OFS, 16'h5A5A);
        rd(RX_FAULT_OFS, 16'h5A5A);
        @(posedge clk_sys_i) {smode, cmode} <= 2'b01;
        rd(RX_FAULT_OFS, 16'hC3C3);
        @(posedge clk_sys_i) cmode <= 1'b0;
        wr(WINDOW_SEL_OFS, 16'h0F05);
        `CHK(tgt, WIN_EXPANSION)
        `CHK(wnum, 8'h05)
        wr(WINDOW_DATA_OFS, 16'hBEEF);
        rd(WINDOW_DATA_OFS, 16'hBEEF);
        wr(WINDOW_SEL_OFS, 16'h0E05);
        `CHK(tgt, WIN_BASEX)
        rd(WINDOW_DATA_OFS, 16'hBEEF);
        wr(WINDOW_SEL_OFS, 16'h0305);
        `CHK(tgt, WIN_RESERVED)
        rd(WINDOW_DATA_OFS, 16'h0000);
        wr(WINDOW_SEL_OFS, 16'h0000);
        `CHK(tgt, WIN_NONE)
        rd(WINDOW_DATA_OFS, 16'h0000);
        rd(16'hFFF6, 16'h0000);
        wr(16'hFFF8, 16'h2007);
        rd(16'hFFF8, 16'h0000);
        $display("test window done");
        close_out();
    end
endmodule : copper_phy_status_error_counters_tb
